/* File: core/cvd_seq.sv */
// Overview of operation
// R1: with double sampling on, each start gives two back-to-back conversions
// R2: busy stays set through both conversions, clears after the second
// R3: without inversion both conversions use the same pre-charge polarities
// R4: first result goes to result pair A, high and low bytes
// R5: second conversion begins two clocks after the first completes
// R6: inversion flips effective pre-charge and guard polarities, stored bits kept
// R7: second result goes to result pair B, high and low bytes
// R8: two guard outputs, own enables, shared guard polarity
// R9: enabled guard outputs driven whenever the converter is on
// R10: guard set to guard polarity at start of each pre-charge
// R11: guard toggles at start of each acquisition, stored polarity kept
// R12: with double and inversion, second-phase guard levels are inverted
// R13: extra capacitance select connects capacitance, removed during conversion
// R14: bus output enable connects conversion bus to monitor pin
// R15: override drives monitor pin in pre-charge to internal polarity
// R16: no monitor pin override outside pre-charge
// R17: software sets monitor pin as input to use it during conversion
// R18: software should invert second sample and subtract results
// R19: software starts by setting busy or by the trigger source
// R20: software polls busy or waits for done, then clears done
// R21: pre-charge lasts programmed instruction cycles, skipped when zero
// R22: acquisition lasts programmed cycles, right after pre-charge or start
// R23: on completion busy clears, done sets, results update
// R24: pre-charge ties hold cap and drives channel per the two polarities
// R25: clearing converter on aborts the sequence back to idle
//
// Purpose: sequencer for a capacitive divider front end with APB registers
// Assumes: converter core and trigger source run on clk_sys
// Notes: pin controls are registered from the next state, except guard levels, which follow guard_lvl_q one clock later
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module cvd_seq
(
   input wire logic clk_sys, // system clock
   input wire logic resetn, // async reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata_q, // apb read data
   output logic pready_q, // apb ready
   output logic pslverr_q, // apb error
   input wire logic trig_in, // special event trigger
   input wire logic adc_done, // converter finished
   input wire logic [9:0] adc_result, // converter result
   output logic adc_start_q, // converter start pulse
   output logic busy_q, // sequence in progress
   output logic conv_done_flag_q, // done flag
   output logic hold_tie_en_q, // hold cap tied to rail
   output logic hold_tie_level_q, // rail: 1 supply
   output logic chan_drive_oe_q, // channel pin driven
   output logic chan_drive_q, // channel pin level
   output logic chan_connect_q, // channel joined to hold cap
   output logic [2:0] extra_cap_q, // extra capacitance select
   output logic bus_pass_q, // bus to monitor pin pass gate
   output logic mon_out_q, // monitor pin level
   output logic mon_oe_q, // monitor pin driven
   output logic guard_a_q, // guard a level
   output logic guard_a_oe_q, // guard a driven
   output logic guard_b_q, // guard b level
   output logic guard_b_oe_q // guard b driven
);
   import cvd_pkg::*;

   ctrl_s ctrl_q;
   guard_s grd_q;
   logic [6:0] pre_cnt_q;
   logic [6:0] acq_cnt_q;
   logic [9:0] res_a_q;
   logic [9:0] res_b_q;
   state_e state_q;
   state_e state_d;
   state_e first_st;
   logic [6:0] cnt_q;
   logic [1:0] div_q;
   logic tick_q;
   logic trig_q;
   logic second_q;
   logic second_d;
   logic inv_d;
   logic guard_lvl_q;
   logic wr;
   logic start;
   logic finish;

   ////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, writes land on the ready edge
   assign wr = psel && penable && pwrite && pready_q;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= psel && penable && !pready_q;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         if (psel && penable && !pready_q)
         begin
            unique case (paddr)
               CTRL_OFF: prdata_q <= {22'h0, conv_done_flag_q, busy_q, ctrl_q};
               TIME_OFF: prdata_q <= {17'h0, acq_cnt_q, 1'b0, pre_cnt_q};
               GUARD_OFF: prdata_q <= {26'h0, grd_q};
               RES_A_OFF: prdata_q <= {16'h0, 6'h00, res_a_q};
               RES_B_OFF: prdata_q <= {16'h0, 6'h00, res_b_q};
               STAT_OFF: prdata_q <= {29'h0, state_q};
               default: pslverr_q <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl_q <= CTRL_RST;
         grd_q <= GUARD_RST;
         pre_cnt_q <= COUNT_RST;
         acq_cnt_q <= COUNT_RST;
      end
      else if (wr)
      begin
         if (paddr == CTRL_OFF)
            ctrl_q <= pwdata[7:0];
         if (paddr == TIME_OFF)
         begin
            pre_cnt_q <= pwdata[PRE_LSB +: 7];
            acq_cnt_q <= pwdata[ACQ_LSB +: 7];
         end
         if (paddr == GUARD_OFF)
            grd_q <= pwdata[5:0];
      end
   end

   // done flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         conv_done_flag_q <= 1'b0;
      else if (finish)
         conv_done_flag_q <= 1'b1; // R23
      else if (wr && paddr == CTRL_OFF && pwdata[DONE_BIT])
         conv_done_flag_q <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // instruction-cycle tick and trigger edge
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         div_q <= 2'h0;
         tick_q <= 1'b0;
         trig_q <= 1'b0;
      end
      else
      begin
         div_q <= (div_q == 2'(INSTR_CYC - 1)) ? 2'h0 : div_q + 2'h1;
         tick_q <= (div_q == 2'(INSTR_CYC - 1));
         trig_q <= trig_in;
      end
   end

   assign start = (wr && paddr == CTRL_OFF && pwdata[GO_BIT])
      || (ctrl_q.trig_en && trig_in && !trig_q); // R19
   // an abort landing in the done cycle must not raise done without a result
   assign finish = state_q == ST_CONV && adc_done && ctrl_q.converter_on
      && state_d == ST_IDLE;

   ////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb
   begin
      if (pre_cnt_q != 7'h00)
         first_st = ST_PRE; // R21
      else if (acq_cnt_q != 7'h00)
         first_st = ST_ACQ; // R22
      else
         first_st = ST_CONV;
   end

   always_comb
   begin
      state_d = state_q;
      if (!ctrl_q.converter_on)
         state_d = ST_IDLE; // R25
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (start)
                  state_d = first_st;
            ST_PRE:
               if (tick_q && cnt_q == pre_cnt_q - 7'h01) // R21
                  state_d = (acq_cnt_q != 7'h00) ? ST_ACQ : ST_CONV; // R22
            ST_ACQ:
               if (tick_q && cnt_q == acq_cnt_q - 7'h01) // R22
                  state_d = ST_CONV;
            ST_CONV:
               if (adc_done)
                  state_d = (ctrl_q.double_sample_en && !second_q) ? ST_GAP : ST_IDLE; // R1
            ST_GAP:
               if (cnt_q == GAP_CYC - 7'h01)
                  state_d = first_st; // R5
            default:
               state_d = ST_IDLE;
         endcase
      end
   end

   always_comb
   begin
      if (state_d == ST_IDLE)
         second_d = 1'b0;
      else if (state_q == ST_GAP)
         second_d = 1'b1;
      else
         second_d = second_q;
   end

   // R3 R6: inversion only acts on the second half, stored bits untouched
   assign inv_d = second_d && ctrl_q.second_invert_en;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 7'h00;
         second_q <= 1'b0;
         busy_q <= 1'b0;
         adc_start_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         second_q <= second_d;
         busy_q <= state_d != ST_IDLE; // R2
         adc_start_q <= state_d == ST_CONV && state_q != ST_CONV;
         if (state_d != state_q)
            cnt_q <= 7'h00;
         else if (state_q == ST_GAP || tick_q)
            cnt_q <= cnt_q + 7'h01;
      end
   end

   // a partial result on abort is not kept; only finished conversions land
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         res_a_q <= RES_RST;
         res_b_q <= RES_RST;
      end
      else if (state_q == ST_CONV && adc_done && ctrl_q.converter_on)
      begin
         if (second_q)
            res_b_q <= adc_result; // R7
         else
            res_a_q <= adc_result; // R4
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin controls, registered from the next state so they align with state_q
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         hold_tie_en_q <= 1'b0;
         hold_tie_level_q <= 1'b0;
         chan_drive_oe_q <= 1'b0;
         chan_drive_q <= 1'b0;
         chan_connect_q <= 1'b0;
         extra_cap_q <= 3'h0;
         bus_pass_q <= 1'b0;
         mon_out_q <= 1'b0;
         mon_oe_q <= 1'b0;
      end
      else
      begin
         hold_tie_en_q <= state_d == ST_PRE; // R24
         hold_tie_level_q <= ctrl_q.int_precharge_pol ^ inv_d; // R24 R6
         chan_drive_oe_q <= state_d == ST_PRE; // R24
         chan_drive_q <= ctrl_q.ext_precharge_pol ^ inv_d; // R24 R6
         chan_connect_q <= state_d == ST_ACQ || state_d == ST_CONV;
         extra_cap_q <= (state_d == ST_CONV) ? 3'h0 : grd_q.extra_cap_sel; // R13
         bus_pass_q <= ctrl_q.bus_out_en; // R14
         mon_out_q <= ctrl_q.int_precharge_pol ^ inv_d; // R15
         mon_oe_q <= state_d == ST_PRE && ctrl_q.bus_out_en
            && ctrl_q.bus_out_override_en; // R15 R16
      end
   end

   // guard level holds between phase starts so it stays driven while on
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         guard_lvl_q <= 1'b0;
      else if (state_d == ST_PRE && state_q != ST_PRE)
         guard_lvl_q <= grd_q.guard_pol ^ inv_d; // R10 R12
      else if (state_d == ST_ACQ && state_q != ST_ACQ)
         guard_lvl_q <= !(grd_q.guard_pol ^ inv_d); // R11 R12
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         guard_a_q <= 1'b0;
         guard_b_q <= 1'b0;
         guard_a_oe_q <= 1'b0;
         guard_b_oe_q <= 1'b0;
      end
      else
      begin
         guard_a_q <= guard_lvl_q; // R8
         guard_b_q <= guard_lvl_q; // R8
         guard_a_oe_q <= ctrl_q.converter_on && grd_q.guard_a_out_en; // R9
         guard_b_oe_q <= ctrl_q.converter_on && grd_q.guard_b_out_en; // R9
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   gap_two_a: assert property (@(posedge clk_sys) // R5
      disable iff (!resetn || !ctrl_q.converter_on)
      (state_q == ST_CONV && adc_done && !second_q && ctrl_q.double_sample_en
      && ctrl_q.converter_on) |=> (state_q == ST_GAP) [*2] ##1 second_q)
      else $error("second conversion not two clocks after first");
   busy_gap_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R2
      (state_q == ST_GAP) |-> busy_q)
      else $error("busy dropped between conversions");
   res_a_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R4
      (state_q == ST_CONV && adc_done && !second_q && ctrl_q.converter_on)
      |=> res_a_q == $past(adc_result))
      else $error("first result not in pair a");
   res_b_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R7
      (state_q == ST_CONV && adc_done && second_q && ctrl_q.converter_on)
      |=> res_b_q == $past(adc_result) && !busy_q)
      else $error("second result not in pair b");
   pol_inv_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R6
      (state_q == ST_PRE && second_q && ctrl_q.second_invert_en && $stable(ctrl_q))
      |-> chan_drive_q != ctrl_q.ext_precharge_pol
      && hold_tie_level_q != ctrl_q.int_precharge_pol)
      else $error("second pre-charge polarity not inverted");
   cap_off_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R13
      (state_q == ST_CONV) |-> extra_cap_q == 3'h0)
      else $error("extra capacitance present during conversion");
   mon_free_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R16
      (state_q != ST_PRE) |-> !mon_oe_q)
      else $error("monitor pin overridden outside pre-charge");
   guard_on_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R9
      (ctrl_q.converter_on && grd_q.guard_a_out_en) |=> guard_a_oe_q)
      else $error("enabled guard not driven");
   abort_idle_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R25
      (!ctrl_q.converter_on) |=> state_q == ST_IDLE && !busy_q)
      else $error("sequence not aborted when converter off");
   done_set_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R23
      finish |=> conv_done_flag_q && !busy_q)
      else $error("completion did not set done");
   guard_acq_a: assert property (@(posedge clk_sys) disable iff (!resetn) // R11
      (state_q == ST_PRE ##1 state_q == ST_ACQ) |=> guard_a_q == !$past(guard_a_q))
      else $error("guard did not toggle at acquisition");
endmodule

/* File: shared/cvd_pkg.sv */
// Purpose: shared constants and types of the capacitive divider sequencer
// Assumes: 100 MHz system clock, 32-bit APB register bus
// Notes: offsets are byte addresses, one aligned word each
package cvd_pkg;
   localparam logic [7:0] CTRL_OFF = 8'h00;
   localparam logic [7:0] TIME_OFF = 8'h04;
   localparam logic [7:0] GUARD_OFF = 8'h08;
   localparam logic [7:0] RES_A_OFF = 8'h0C;
   localparam logic [7:0] RES_B_OFF = 8'h10;
   localparam logic [7:0] STAT_OFF = 8'h14;
   localparam int GO_BIT = 8;
   localparam int DONE_BIT = 9;
   localparam int PRE_LSB = 0;
   localparam int ACQ_LSB = 8;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [5:0] GUARD_RST = 6'h00;
   localparam logic [6:0] COUNT_RST = 7'h00;
   localparam logic [9:0] RES_RST = 10'h000;
   // one instruction cycle is four system clocks
   localparam int CLK_NS = 10;
   localparam int INSTR_NS = 40;
   localparam int INSTR_CYC = (INSTR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [6:0] GAP_CYC = 7'h02;

   typedef struct packed {
      logic trig_en;
      logic bus_out_override_en;
      logic bus_out_en;
      logic int_precharge_pol;
      logic ext_precharge_pol;
      logic second_invert_en;
      logic double_sample_en;
      logic converter_on;
   } ctrl_s;

   typedef struct packed {
      logic [2:0] extra_cap_sel;
      logic guard_pol;
      logic guard_b_out_en;
      logic guard_a_out_en;
   } guard_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_PRE = 3'b001,
      ST_ACQ = 3'b010,
      ST_CONV = 3'b011,
      ST_GAP = 3'b100
   } state_e;
endpackage

/* File: sim/conv_model.sv */
// Purpose: converter stand-in that answers start pulses
// Assumes: start is a one-cycle pulse on clk_sys
// Notes: result toggles to its inverse every clock between answers
`timescale 1ns/1ps
module conv_model
(
   input wire logic clk_sys, // clock
   input wire logic resetn, // async reset, low
   input wire logic start, // begin a conversion
   input wire logic [7:0] lat, // answer delay, 1 or more
   output logic done_q, // one-cycle finish pulse
   output logic [9:0] result_q // valid only with done_q
);
   logic [7:0] cnt_q;
   logic [9:0] n_q;
   ////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= 8'h00;
         n_q <= 10'h000;
         done_q <= 1'b0;
         result_q <= 10'h3FF;
      end
      else
      begin
         done_q <= 1'b0;
         // stale data must not look valid
         result_q <= ~result_q;
         if (start)
            cnt_q <= lat;
         else if (cnt_q != 8'h00)
            cnt_q <= cnt_q - 8'h01;
         if (cnt_q == 8'h01 && !start)
         begin
            done_q <= 1'b1;
            result_q <= 10'h1C3 ^ n_q;
            n_q <= n_q + 10'h001;
         end
      end
   end
endmodule

/* File: sim/testbench.sv */
// Purpose: self-checking bench of the divider sequencer
// Assumes: conv_model answers on the converter side
// Notes: busy is polled over APB as software would
`timescale 1ns/1ps
module testbench;
   import cvd_pkg::*;
   logic clk_sys, resetn, psel, penable, pwrite, trig_in, adc_done, er, hold_q;
   logic pready_q, pslverr_q, adc_start_q, busy_q, conv_done_flag_q, chan_connect_q;
   logic hold_tie_en_q, hold_tie_level_q, chan_drive_oe_q, chan_drive_q, bus_pass_q;
   logic mon_out_q, mon_oe_q, guard_a_q, guard_a_oe_q, guard_b_q, guard_b_oe_q;
   logic [7:0] paddr, lat;
   logic [31:0] pwdata, prdata_q, rd;
   logic [9:0] adc_result;
   logic [2:0] extra_cap_q;
   logic epol[16], ipol[16], gpre[16], gacq[16], bz[16];
   int errors, checked, ns, nd, npc, nmo, cyc, tdone, gap, k0;
   cvd_seq dut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
      .pready_q, .pslverr_q, .trig_in, .adc_done, .adc_result, .adc_start_q, .busy_q,
      .conv_done_flag_q, .hold_tie_en_q, .hold_tie_level_q, .chan_drive_oe_q,
      .chan_drive_q, .chan_connect_q, .extra_cap_q, .bus_pass_q, .mon_out_q, .mon_oe_q,
      .guard_a_q, .guard_a_oe_q, .guard_b_q, .guard_b_oe_q);
   conv_model cm (.clk_sys, .resetn, .start(adc_start_q), .lat, .done_q(adc_done),
      .result_q(adc_result));
   ////////////////////////////////////////
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // per-conversion snapshots, indexed by starts seen so far
   always @(posedge clk_sys)
   begin
      if (hold_tie_en_q === 1'b1)
      begin
         epol[ns] = chan_drive_q;
         ipol[ns] = hold_tie_level_q;
         gpre[ns] = guard_a_q;
         npc++;
         cmp({chan_drive_oe_q, chan_connect_q}, 2'b10, "pre pins");
         if (hold_q === 1'b0)
            gap = cyc - tdone;
      end
      if (adc_start_q === 1'b1)
      begin
         gacq[ns] = guard_a_q;
         bz[ns] = busy_q;
         cmp(extra_cap_q, 0, "cap in conv");
         cmp({chan_connect_q, chan_drive_oe_q, guard_b_q}, {2'b10, guard_a_q}, "conv pins");
         ns++;
      end
      if (adc_done === 1'b1)
      begin
         tdone = cyc;
         nd++;
      end
      if (mon_oe_q === 1'b1)
      begin
         nmo++;
         cmp({hold_tie_en_q, mon_out_q}, {1'b1, hold_tie_level_q}, "monitor");
      end
      hold_q = hold_tie_en_q;
      cyc++;
   end
   ////////////////////////////////////////
   task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic finish_test;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready_q !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge clk_sys);
      end
      rd = prdata_q;
      er = pslverr_q;
      if (n == 50)
      begin
         errors++;
         finish_test;
      end
      else
      begin
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      rd = 32'h100;
      while (rd[GO_BIT] !== 1'b0 && n < 100)
      begin
         n++;
         apb(1'b0, CTRL_OFF, 32'h0);
      end
      if (n == 100)
      begin
         errors++;
         finish_test;
      end
   endtask
   function automatic logic [31:0] rv(input int k);
      return {22'h0, 10'h1C3 ^ k[9:0]};
   endfunction
   // configure, start by write or trigger edge, poll until idle
   task automatic run(input logic [7:0] c, input logic [31:0] t, input logic [31:0] g,
      input logic go);
      apb(1'b1, GUARD_OFF, g);
      apb(1'b1, TIME_OFF, t);
      apb(1'b1, CTRL_OFF, {22'h0, 2'b10, c});
      ns = 0;
      npc = 0;
      nmo = 0;
      k0 = nd;
      if (go)
         apb(1'b1, CTRL_OFF, {22'h0, 2'b01, c});
      else
      begin
         trig_in <= 1'b1;
         @(posedge clk_sys);
         trig_in <= 1'b0;
      end
      wait_idle;
      cmp(rd[DONE_BIT], 1, "done flag");
      apb(1'b0, RES_A_OFF, 32'h0);
      cmp(rd, rv(k0), "result a");
   endtask
   ////////////////////////////////////////
   task automatic t_regs;
      apb(1'b0, CTRL_OFF, 32'h0);
      cmp(rd, 0, "ctrl reset");
      apb(1'b0, TIME_OFF, 32'h0);
      cmp(rd, 0, "time reset");
      apb(1'b0, 8'h20, 32'h0);
      cmp(er, 1, "unmapped error");
      cmp(rd, 0, "unmapped data");
      $display("test regs done");
   endtask
   task automatic t_single;
      lat <= 8'h01;
      run(8'h09, 32'h0302, 32'h2F, 1'b1);
      cmp(ns, 1, "one conversion");
      cmp({epol[0], gpre[0], gacq[0]}, 3'b110, "pre levels");
      cmp(npc inside {[5:8]}, 1, "pre length");
      cmp({guard_a_oe_q, guard_b_oe_q, extra_cap_q}, 5'h1D, "idle pins");
      apb(1'b0, GUARD_OFF, 32'h0);
      cmp(rd, 32'h2F, "guard kept");
      $display("test single done");
   endtask
   task automatic t_dbl_inv;
      lat <= 8'h28;
      run(8'h77, 32'h0302, 32'h05, 1'b1);
      cmp(ns, 2, "two conversions");
      cmp(bz[1], 1, "busy between");
      cmp({epol[0], epol[1], ipol[0], ipol[1]}, 4'h6, "inverted pol");
      cmp({gpre[0], gpre[1], gacq[1]}, 3'b101, "inverted guard");
      // done seen at one edge, second pre-charge seen three edges on: two gap cycles
      cmp(gap, 3, "gap");
      cmp({nmo > 0, bus_pass_q}, 2'b11, "monitor");
      apb(1'b0, RES_B_OFF, 32'h0);
      cmp(rd, rv(k0 + 1), "result b");
      apb(1'b0, CTRL_OFF, 32'h0);
      cmp(rd[7:0], 8'h77, "ctrl kept");
      $display("test double inverted done");
   endtask
   task automatic t_dbl_same;
      lat <= 8'h01;
      run(8'h1B, 32'h0302, 32'h01, 1'b1);
      cmp(ns, 2, "two conversions");
      cmp({epol[0], epol[1], ipol[0], ipol[1]}, 4'hF, "same pol");
      $display("test double plain done");
   endtask
   task automatic t_trig;
      lat <= 8'h03;
      run(8'h81, 32'h0200, 32'h03, 1'b0);
      cmp(ns, 1, "trigger one");
      cmp(npc, 0, "no pre");
      $display("test trigger done");
   endtask
   task automatic t_abort;
      apb(1'b1, TIME_OFF, 32'h0302);
      apb(1'b1, CTRL_OFF, 32'h203);
      ns = 0;
      apb(1'b1, CTRL_OFF, 32'h103);
      apb(1'b1, CTRL_OFF, 32'h002);
      apb(1'b0, STAT_OFF, 32'h0);
      cmp(rd[2:0], 0, "abort state");
      cmp(ns, 0, "abort no conversion");
      cmp({busy_q, guard_a_oe_q}, 0, "abort pins");
      apb(1'b0, CTRL_OFF, 32'h0);
      cmp(rd[9:8], 0, "no done");
      $display("test abort done");
   endtask
   ////////////////////////////////////////
   initial
   begin
      resetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      trig_in = 1'b0;
      lat = 8'h01;
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs;
      t_single;
      t_dbl_inv;
      t_dbl_same;
      t_trig;
      t_abort;
      finish_test;
   end
endmodule
